/* rtl/sgor_pkg.sv */
package sgor_pkg;
    // Native register addresses
    localparam logic [7:0] ADDR_COMMON_TRIGGER = 8'h20;
    localparam logic [7:0] ADDR_GENERAL_STATUS = 8'h22;
    localparam logic [7:0] ADDR_COMPARATOR_STATUS = 8'h23;
    localparam logic [7:0] ADDR_PIN_CONFIGURATION = 8'h24;
    // Paged PMBus command codes
    localparam logic [7:0] PMB_CMD_PAGE = 8'h00;
    localparam logic [7:0] PMB_PAGE_REGS = 8'hff;
    localparam logic [7:0] PMB_PAGE_RESET = 8'h00;
    localparam logic [7:0] PMB_COMMON_TRIGGER = 8'he4;
    localparam logic [7:0] PMB_GENERAL_STATUS = 8'he6;
    localparam logic [7:0] PMB_COMPARATOR_STATUS = 8'he7;
    localparam logic [7:0] PMB_PIN_CONFIGURATION = 8'he8;
    // Register select, one bit per register
    localparam int SEL_TRIG = 0;
    localparam int SEL_GEN = 1;
    localparam int SEL_CMP = 2;
    localparam int SEL_PIN = 3;
    // General status fields
    localparam int GS_FACTORY_CRC = 15;
    localparam int GS_USER_CRC = 14;
    localparam int GS_BUSY_LSB = 9;
    // Comparator status fields
    localparam int CS_PROTECT = 8;
    localparam int CS_WINDOW_LSB = 4;
    localparam int CS_SYNCED_LSB = 0;
    // Pin configuration fields
    localparam int PC_FILTER_EN = 15;
    localparam int PC_OUTPUT_EN = 13;
    localparam int PC_SOURCE_LSB = 9;
    localparam logic [15:0] PC_WRITE_MASK = 16'hbfff;
    localparam logic [15:0] PIN_CONFIG_RESET = 16'h0000;
    localparam logic [15:0] COMPARATOR_STATUS_RESET = 16'h0000;
    // Common trigger fields
    localparam int CT_PROTECT = 3;
    // Output source codes
    localparam logic [3:0] SRC_MEMORY_BUSY = 4'h1;
    localparam logic [3:0] SRC_BUSY_BASE = 4'h4;
    localparam logic [3:0] SRC_WINDOW_BASE = 4'h8;
    // Identification value is arbitrary
    localparam logic [7:0] IDENT_CODE = 8'h5a;
    // Glitch filter settle time
    localparam int FILTER_NS = 16;
    localparam int CLK_NS = 4;
    localparam int FILTER_CYCLES = (FILTER_NS + CLK_NS - 1) / CLK_NS;

    typedef struct packed {
        logic write;
        logic read;
        logic pmbus;
        logic [7:0] addr;
        logic [15:0] wdata;
    } sgor_req_type;

    typedef struct packed {
        logic factory_load_fail;
        logic user_load_fail;
        logic soft_reset;
        logic memory_busy_flag;
        logic [3:0] channel_busy;
        logic protect_done;
        logic [3:0] window_raw;
        logic [3:0] window_clear;
        logic window_latch_enable;
        logic [3:0] compare_raw;
    } sgor_status_type;

    typedef enum logic [2:0] {
        PROT_IDLE = 3'b001,
        PROT_RUN = 3'b010,
        PROT_DONE = 3'b100
    } sgor_prot_type;
endpackage : sgor_pkg

/* rtl/sgor_input_filter.sv */
`timescale 1ns/1ns
module sgor_input_filter
    import sgor_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Pin side
    input wire logic pin_in,
    input wire logic filter_enable,
    // Result
    output logic pin_level
);
    logic sync_a;
    logic sync_b;
    logic [2:0] stable_count;
    wire changed = (sync_b != pin_level);
    wire settled = (stable_count == 3'(FILTER_CYCLES - 1));

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= pin_in;
            sync_b <= sync_a;
        end
    end

    // A change must hold for the whole settle time before it passes
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stable_count <= 3'h0;
            pin_level <= 1'b0;
        end else if (!filter_enable) begin
            stable_count <= 3'h0;
            pin_level <= sync_b;
        end else if (!changed) begin
            stable_count <= 3'h0;
        end else if (settled) begin
            stable_count <= 3'h0;
            pin_level <= sync_b;
        end else begin
            stable_count <= stable_count + 3'h1;
        end
    end
endmodule : sgor_input_filter

/* rtl/sgor_regs.sv */
`timescale 1ns/1ns
// What this block does
// - A failed factory memory load sets status bit 15, held until soft reset or power cycle.
// - A failed user memory load sets status bit 14, blocks nothing, and soft reset clears it.
// - Bits 12 to 9 show each channel busy, and the host sends no command to a busy channel.
// - Bits 7 to 0 of the general status hold a fixed read-only identification code.
// - The protect-complete flag in bit 8 rises only after protect finishes and clears on read.
// - Bits 7 to 4 show window results, latched or live per the window latch enable.
// - Bits 3 to 0 show each comparator output after synchronising to the clock.
// - Pin configuration bit 15 low bypasses the input glitch filter, high filters the input.
// - The pin is driven as an output only while pin configuration bit 13 is one.
// - Bits 12 to 9 pick the output source: memory busy, channel busy or window result.
// - The pin configuration register sits at 24h and resets to 0000h.
// - The comparator status register sits at 23h and resets to 0000h.
// - The general status register sits at 22h with bits 13 and 8 reading zero.
// - Over PMBus, page FFh with codes E6h, E7h, E8h reaches the three registers.
// - Writing one to trigger bit 3 at 20h starts protect, and the bit clears itself.
module sgor_regs
    import sgor_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register access
    input wire sgor_req_type req,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // Status sources
    input wire sgor_status_type status,
    // General-purpose pin
    input wire logic gpio_in,
    output logic gpio_out,
    output logic gpio_oe,
    output logic gpio_in_level,
    // Protect control
    output logic protect_start
);
    logic factory_load_crc_error;
    logic user_load_crc_error;
    logic [3:0] window_compare_result;
    logic [3:0] cmp_sync_a;
    logic [3:0] synced_compare_result;
    logic [15:0] pin_configuration;
    logic [7:0] pmbus_page;
    sgor_prot_type prot_state;
    sgor_prot_type next_prot_state;
    logic filtered_level;

    // Same decode serves read and write
    function automatic logic [3:0] decode_addr(input logic pmbus, input logic [7:0] page, input logic [7:0] addr);
        logic [3:0] sel;
        sel = 4'h0;
        if (pmbus) begin
            if (page == PMB_PAGE_REGS) begin
                sel[SEL_TRIG] = (addr == PMB_COMMON_TRIGGER);
                sel[SEL_GEN] = (addr == PMB_GENERAL_STATUS);
                sel[SEL_CMP] = (addr == PMB_COMPARATOR_STATUS);
                sel[SEL_PIN] = (addr == PMB_PIN_CONFIGURATION);
            end
        end else begin
            sel[SEL_TRIG] = (addr == ADDR_COMMON_TRIGGER);
            sel[SEL_GEN] = (addr == ADDR_GENERAL_STATUS);
            sel[SEL_CMP] = (addr == ADDR_COMPARATOR_STATUS);
            sel[SEL_PIN] = (addr == ADDR_PIN_CONFIGURATION);
        end
        return sel;
    endfunction : decode_addr

    wire [3:0] sel = decode_addr(req.pmbus, pmbus_page, req.addr);
    wire write_page = req.write && req.pmbus && (req.addr == PMB_CMD_PAGE);
    wire write_pin = req.write && sel[SEL_PIN];
    wire write_protect = req.write && sel[SEL_TRIG] && req.wdata[CT_PROTECT];
    wire read_cmp = req.read && sel[SEL_CMP];
    wire protect_flag = (prot_state == PROT_DONE);

    wire [15:0] general_status = {factory_load_crc_error, user_load_crc_error, 1'b0,
                                  status.channel_busy, 1'b0, IDENT_CODE};
    wire [15:0] comparator_status = {7'h00, protect_flag, window_compare_result,
                                     synced_compare_result};
    wire [15:0] read_mux = sel[SEL_GEN] ? general_status :
                           sel[SEL_CMP] ? comparator_status :
                           sel[SEL_PIN] ? pin_configuration :
                           16'h0000;

    wire [3:0] source_code = pin_configuration[PC_SOURCE_LSB +: 4];
    wire busy_code = (source_code[3:2] == SRC_BUSY_BASE[3:2]);
    wire window_code = (source_code[3:2] == SRC_WINDOW_BASE[3:2]);
    wire next_gpio_out = (source_code == SRC_MEMORY_BUSY) ? status.memory_busy_flag :
                         busy_code ? status.channel_busy[source_code[1:0]] :
                         window_code ? window_compare_result[source_code[1:0]] :
                         1'b0;

    // Protect tracker; completion beats a same-cycle read
    always_comb begin
        case (prot_state)
            PROT_IDLE: next_prot_state = write_protect ? PROT_RUN : PROT_IDLE;
            PROT_RUN: next_prot_state = status.protect_done ? PROT_DONE : PROT_RUN;
            PROT_DONE: next_prot_state = write_protect ? PROT_RUN : (read_cmp ? PROT_IDLE : PROT_DONE);
            default: next_prot_state = PROT_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prot_state <= PROT_IDLE;
        end else begin
            prot_state <= next_prot_state;
        end
    end

    // Trigger bit is never stored, so it clears itself and reads zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            protect_start <= 1'b0;
        end else begin
            protect_start <= write_protect;
        end
    end

    // Load errors: a new failure wins over a soft reset in the same cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            factory_load_crc_error <= 1'b0;
        end else begin
            factory_load_crc_error <= status.factory_load_fail |
                                      (factory_load_crc_error & ~status.soft_reset);
        end
    end

    // User load error blocks nothing; it is only reported
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            user_load_crc_error <= 1'b0;
        end else begin
            user_load_crc_error <= status.user_load_fail |
                                   (user_load_crc_error & ~status.soft_reset);
        end
    end

    // Per channel: two-flop synchroniser and window latch; set beats clear so a pulse never slips past
    for (genvar ch = 0; ch < 4; ch++) begin : g_channel
        wire window_held;
        wire next_window_bit;
        assign window_held = (window_compare_result[ch] & ~status.window_clear[ch]) | status.window_raw[ch];
        assign next_window_bit = status.window_latch_enable ? window_held : status.window_raw[ch];

        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                cmp_sync_a[ch] <= 1'b0;
                synced_compare_result[ch] <= 1'b0;
            end else begin
                cmp_sync_a[ch] <= status.compare_raw[ch];
                synced_compare_result[ch] <= cmp_sync_a[ch];
            end
        end

        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                window_compare_result[ch] <= 1'b0;
            end else begin
                window_compare_result[ch] <= next_window_bit;
            end
        end
    end : g_channel

    // Read-only registers simply ignore writes
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_configuration <= PIN_CONFIG_RESET;
        end else begin
            if (write_pin) begin
                pin_configuration <= req.wdata & PC_WRITE_MASK;
            end
        end
    end

    // Page starts at zero, so the host must select the register page first
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pmbus_page <= PMB_PAGE_RESET;
        end else begin
            if (write_page) begin
                pmbus_page <= req.wdata[7:0];
            end
        end
    end

    // Unmapped and trigger reads still answer, with zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata <= req.read ? read_mux : 16'h0000;
            reg_rvalid <= req.read;
        end
    end

    // Source is gated too, so the pin never shows a stale level once output turns off
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gpio_out <= 1'b0;
            gpio_oe <= 1'b0;
        end else begin
            gpio_out <= next_gpio_out & pin_configuration[PC_OUTPUT_EN];
            gpio_oe <= pin_configuration[PC_OUTPUT_EN];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gpio_in_level <= 1'b0;
        end else begin
            gpio_in_level <= filtered_level;
        end
    end

    sgor_input_filter u_filter (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin_in(gpio_in),
        .filter_enable(pin_configuration[PC_FILTER_EN]),
        .pin_level(filtered_level)
    );
endmodule : sgor_regs

/* sim/sgor_regs_monitor.sv */
`timescale 1ns/1ns
module sgor_regs_monitor
    import sgor_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register access
    input wire sgor_req_type req,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    // Status and pin
    input wire sgor_status_type status,
    input wire logic gpio_out,
    input wire logic gpio_oe,
    input wire logic protect_start
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire logic nat_rd = req.read && !req.pmbus;
    wire logic gen_rd = nat_rd && req.addr == ADDR_GENERAL_STATUS;
    wire logic cmp_rd = nat_rd && req.addr == ADDR_COMPARATOR_STATUS;
    wire logic nat_wr = req.write && !req.pmbus;
    wire logic pin_wr = nat_wr && req.addr == ADDR_PIN_CONFIGURATION;
    wire logic trig_wr = nat_wr && req.addr == ADDR_COMMON_TRIGGER && req.wdata[CT_PROTECT];
    AST_READ_ANSWER: assert property (req.read |=> reg_rvalid)
        else $error("read not answered");
    AST_NO_SPURIOUS: assert property (!req.read |=> !reg_rvalid)
        else $error("answer without read");
    AST_GEN_FIXED: assert property (gen_rd |=> !reg_rdata[13] && !reg_rdata[8] && reg_rdata[7:0] == IDENT_CODE)
        else $error("general status fixed bits wrong");
    AST_BUSY_LIVE: assert property (gen_rd |=> reg_rdata[12:9] == $past(status.channel_busy))
        else $error("busy bits wrong");
    AST_CMP_UNUSED: assert property (cmp_rd |=> reg_rdata[15:9] == 7'h00)
        else $error("comparator unused bits set");
    AST_PROT_START: assert property (trig_wr |=> protect_start)
        else $error("protect not started");
    AST_PROT_CAUSE: assert property (protect_start |-> $past(req.write) && $past(req.wdata[CT_PROTECT]))
        else $error("protect started without trigger");
    AST_OE_FOLLOWS: assert property (pin_wr |-> ##2 gpio_oe == $past(req.wdata[PC_OUTPUT_EN], 2))
        else $error("output enable does not follow config");
    AST_OUT_GATED: assert property (!gpio_oe |-> !gpio_out)
        else $error("pin driven while output disabled");
endmodule : sgor_regs_monitor

bind sgor_regs sgor_regs_monitor i_sgor_regs_monitor(.sys_clk(sys_clk), .rst(rst), .req(req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .status(status), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .protect_start(protect_start));

/* sim/sgor_host.sv */
`timescale 1ns/1ns
module sgor_host
    import sgor_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Register access
    output sgor_req_type req,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid
);
    // No channel commands are issued, so a busy channel is never addressed
    initial req = '0;
    task automatic wr(input logic pm, input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk) #1;
        req = '{1'b1, 1'b0, pm, a, d};
        @(posedge sys_clk) #1;
        req = '0;
    endtask : wr
    // Answer stands one cycle, so it is taken right after the edge that registers it
    task automatic rd(input logic pm, input logic [7:0] a, output logic [15:0] d, output logic v);
        @(posedge sys_clk) #1;
        req = '{1'b0, 1'b1, pm, a, 16'h0000};
        @(posedge sys_clk) #1;
        req = '0;
        d = reg_rdata;
        v = reg_rvalid;
    endtask : rd
endmodule : sgor_host

/* sim/sgor_regs_tb.sv */
`timescale 1ns/1ns
module sgor_regs_tb
    import sgor_pkg::*;
;
    logic sys_clk, rst, gpio_in, reg_rvalid, gpio_out, gpio_oe, gpio_in_level, protect_start, e;
    logic [15:0] reg_rdata;
    sgor_req_type req;
    sgor_status_type st;
    int failures = 0;
    int total_checks = 0;
    sgor_regs i_sgor_regs(.sys_clk(sys_clk), .rst(rst), .req(req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .status(st), .gpio_in(gpio_in), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .gpio_in_level(gpio_in_level), .protect_start(protect_start));
    sgor_host i_sgor_host(.sys_clk(sys_clk), .req(req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic rchk(input logic pm, input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        i_sgor_host.rd(pm, a, d, v);
        check({15'h0000, v}, 16'h0001);
        check(d, exp);
    endtask : rchk
    task automatic w(input logic pm, input logic [7:0] a, input logic [15:0] d);
        i_sgor_host.wr(pm, a, d);
    endtask : w
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step
    task automatic tally_and_finish();
        if (failures == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Whole sequence needs well under 2000 cycles
    initial begin
        #20000;
        failures++;
        tally_and_finish();
    end
    initial begin
        rst = 1'b1;
        st = '0;
        gpio_in = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1 rst = 1'b0;
        rchk(0, ADDR_PIN_CONFIGURATION, PIN_CONFIG_RESET);
        rchk(0, ADDR_COMPARATOR_STATUS, COMPARATOR_STATUS_RESET);
        rchk(0, ADDR_GENERAL_STATUS, {8'h00, IDENT_CODE});
        rchk(0, 8'h30, 16'h0000);
        w(0, ADDR_GENERAL_STATUS, 16'hffff);
        rchk(0, ADDR_GENERAL_STATUS, {8'h00, IDENT_CODE});
        w(0, ADDR_COMPARATOR_STATUS, 16'hffff);
        rchk(0, ADDR_COMPARATOR_STATUS, 16'h0000);
        w(0, ADDR_PIN_CONFIGURATION, 16'hffff);
        rchk(0, ADDR_PIN_CONFIGURATION, 16'hbfff);
        st.factory_load_fail = 1'b1;
        st.user_load_fail = 1'b1;
        st.channel_busy = 4'ha;
        step(1);
        st.factory_load_fail = 1'b0;
        st.user_load_fail = 1'b0;
        rchk(0, ADDR_GENERAL_STATUS, {8'hd4, IDENT_CODE});
        rchk(0, ADDR_PIN_CONFIGURATION, 16'hbfff);
        st.soft_reset = 1'b1;
        step(1);
        st.soft_reset = 1'b0;
        rchk(0, ADDR_GENERAL_STATUS, {8'h14, IDENT_CODE});
        st.compare_raw = 4'h5;
        st.window_raw = 4'h3;
        step(3);
        rchk(0, ADDR_COMPARATOR_STATUS, 16'h0035);
        st.window_latch_enable = 1'b1;
        step(1);
        st.window_raw = 4'h0;
        step(2);
        rchk(0, ADDR_COMPARATOR_STATUS, 16'h0035);
        st.window_clear = 4'hf;
        step(1);
        st.window_clear = 4'h0;
        rchk(0, ADDR_COMPARATOR_STATUS, 16'h0005);
        w(0, ADDR_COMMON_TRIGGER, 16'h0008);
        check({15'h0000, protect_start}, 16'h0001);
        rchk(0, ADDR_COMPARATOR_STATUS, 16'h0005);
        st.protect_done = 1'b1;
        step(1);
        st.protect_done = 1'b0;
        rchk(0, ADDR_COMPARATOR_STATUS, 16'h0105);
        rchk(0, ADDR_COMPARATOR_STATUS, 16'h0005);
        rchk(1, PMB_PIN_CONFIGURATION, 16'h0000);
        w(1, PMB_CMD_PAGE, {8'h00, PMB_PAGE_REGS});
        rchk(1, PMB_PIN_CONFIGURATION, 16'hbfff);
        rchk(1, PMB_GENERAL_STATUS, {8'h14, IDENT_CODE});
        rchk(1, PMB_COMPARATOR_STATUS, 16'h0005);
        st.memory_busy_flag = 1'b1;
        st.channel_busy = 4'h4;
        st.window_latch_enable = 1'b0;
        st.window_raw = 4'h2;
        for (int c = 0; c < 16; c++) begin
            w(0, ADDR_PIN_CONFIGURATION, {3'b001, 4'(c), 9'h000});
            step(2);
            e = (c == 1) ? 1'b1 : (c >= 4 && c <= 7) ? st.channel_busy[c-4] :
                (c >= 8 && c <= 11) ? st.window_raw[c-8] : 1'b0;
            check({14'h0000, gpio_oe, gpio_out}, {14'h0000, 1'b1, e});
        end
        w(0, ADDR_PIN_CONFIGURATION, 16'h0000);
        step(2);
        check({14'h0000, gpio_oe, gpio_out}, 16'h0000);
        gpio_in = 1'b1;
        step(5);
        check({15'h0000, gpio_in_level}, 16'h0001);
        gpio_in = 1'b0;
        w(0, ADDR_PIN_CONFIGURATION, 16'h8000);
        step(6);
        gpio_in = 1'b1;
        step(2);
        gpio_in = 1'b0;
        step(12);
        check({15'h0000, gpio_in_level}, 16'h0000);
        gpio_in = 1'b1;
        step(12);
        check({15'h0000, gpio_in_level}, 16'h0001);
        tally_and_finish();
    end
endmodule : sgor_regs_tb
